/* File: logic/mxd_cfg.svh */
`ifndef MXD_CFG_SVH
`define MXD_CFG_SVH

`define MXD_OFS_CMD      8'h00
`define MXD_OFS_ACC      8'h04
`define MXD_OFS_PC       8'h08
`define MXD_OFS_PSW      8'h0C
`define MXD_OFS_STAT     8'h10
`define MXD_OFS_MADDR    8'h14
`define MXD_OFS_MDATA    8'h18
`define MXD_OFS_VEC      8'h1C

`define MXD_CMD_OP_LSB   0
`define MXD_CMD_MODE_LSB 5
`define MXD_CMD_IMM_LSB  8
`define MXD_CMD_DIR_LSB  16
`define MXD_CMD_BIT_LSB  24

`define MXD_PSW_C        0
`define MXD_PSW_HC       1
`define MXD_PSW_GIE      2
`define MXD_PSW_PEND     3
`define MXD_STAT_BUSY    0
`define MXD_STAT_SKIP    1

`define MXD_REG_PAGE     4'hF
`define MXD_ADDR_X       8'hFC
`define MXD_ADDR_SP      8'hFD
`define MXD_ADDR_B       8'hFE

`define MXD_RST_VEC      15'h00FE

`endif

/* File: logic/mxd_pkg.sv */
package mxd_pkg;

    typedef enum logic [4:0] {
        OP_IDLE      = 5'h00,
        OP_ADD       = 5'h01,
        OP_ADC       = 5'h02,
        OP_DIFFERENCE_WITH_BORROW      = 5'h03,
        OP_AND       = 5'h04,
        OP_OR        = 5'h05,
        OP_XOR       = 5'h06,
        OP_MASK_SKIP = 5'h07,
        OP_EQ_MD     = 5'h08,
        OP_EQ        = 5'h09,
        OP_NE        = 5'h0A,
        OP_GT        = 5'h0B,
        OP_NIB       = 5'h0C,
        OP_CNT_SKIP  = 5'h0D,
        OP_BSET      = 5'h0E,
        OP_BCLR      = 5'h0F,
        OP_BTEST     = 5'h10,
        OP_PEND_CLR  = 5'h11,
        OP_XCHG      = 5'h12,
        OP_LDA       = 5'h13,
        OP_LDB       = 5'h14,
        OP_LDMEM     = 5'h15,
        OP_LDREG     = 5'h16,
        OP_VEC       = 5'h17
    } mxd_op_t;

    typedef enum logic [2:0] {
        MD_DIR    = 3'h0,
        MD_PB     = 3'h1,
        MD_PX     = 3'h2,
        MD_IMM    = 3'h3,
        MD_PB_INC = 3'h4,
        MD_PB_DEC = 3'h5,
        MD_PX_INC = 3'h6,
        MD_PX_DEC = 3'h7
    } mxd_mode_t;

    typedef enum logic [2:0] {
        ALU_ADD  = 3'h0,
        ALU_ADC  = 3'h1,
        ALU_DIFFERENCE_WITH_BORROW = 3'h2,
        ALU_AND  = 3'h3,
        ALU_OR   = 3'h4,
        ALU_XOR  = 3'h5
    } mxd_alu_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_EXEC = 3'h1,
        ST_VHI  = 3'h2,
        ST_VLO  = 3'h3,
        ST_VEND = 3'h4
    } mxd_st_t;

    typedef struct packed {
        mxd_st_t   st;
        mxd_op_t   op;
        mxd_mode_t mode;
        logic [7:0]  imm;
        logic [7:0]  dir;
        logic [2:0]  bitn;
        logic [7:0]  acc;
        logic [6:0]  pcHi;
        logic [7:0]  pcLo;
        logic        carry;
        logic        half;
        logic        global_irq_enable;
        logic        softPend;
        logic        skip;
        logic [7:0]  memAddr;
        logic [14:0] vecAddr;
        logic [14:0] pmemAddr;
        logic        pmemRd;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } mxd_state_t;

endpackage

/* File: logic/mxd_alu_if.sv */
`timescale 1ns/10ps
interface mxd_alu_if;
    import mxd_pkg::*;
    logic [7:0]  a;
    logic [7:0]  b;
    logic        cin;
    mxd_alu_op_t op;
    logic [7:0]  res;
    logic        cout;
    logic        hcout;
    modport core (output a, b, cin, op, input res, cout, hcout);
    modport alu  (input a, b, cin, op, output res, cout, hcout);
endinterface

/* File: logic/mxd_alu.sv */
`timescale 1ns/10ps
module mxd_alu (
    mxd_alu_if.alu bus
);
    import mxd_pkg::*;

    logic [7:0] opnd;
    logic [4:0] low;
    logic [8:0] full;

    always_comb begin
        // difference is a plus the one's complement plus carry
        opnd = (bus.op == ALU_DIFFERENCE_WITH_BORROW) ? ~bus.b : bus.b; // see RQ8
        low  = {1'b0, bus.a[3:0]} + {1'b0, opnd[3:0]} + {4'h0, bus.cin};
        full = {1'b0, bus.a} + {1'b0, opnd} + {8'h00, bus.cin}; // see RQ7
        bus.cout  = full[8];
        bus.hcout = low[4];
        case (bus.op)
            ALU_ADD, ALU_ADC, ALU_DIFFERENCE_WITH_BORROW: bus.res = full[7:0];
            ALU_AND: bus.res = bus.a & bus.b; // see RQ9
            ALU_OR:  bus.res = bus.a | bus.b;
            ALU_XOR: bus.res = bus.a ^ bus.b;
            default: bus.res = full[7:0];
        endcase
    end
endmodule

/* File: logic/mxd_core.sv */
// Function
// RQ1: idle op changes nothing but advances the program counter.
// RQ2: vector dispatch loads counter high and low bytes from adjacent program bytes.
// RQ3: accumulator, both pointers and stack pointer are eight bits.
// RQ4: program counter is 15 bits: 7-bit high part, 8-bit low part.
// RQ5: carry, nibble overflow and irq enable are separate single status bits.
// RQ6: register memory is F0 to FF and holds both pointers and stack pointer.
// RQ7: add with carry sums a, operand and carry; plain add ignores carry.
// RQ8: difference with borrow adds complemented operand plus carry, updates both flags.
// RQ9: and, or, xor combine accumulator with operand into accumulator.
// RQ10: mask test skip skips next when accumulator and immediate give zero.
// RQ11: direct byte equal to immediate runs next, otherwise skips.
// RQ12: equal, unequal, greater tests on accumulator run next only when true.
// RQ13: pointer nibble test runs next only when low nibble differs from immediate.
// RQ14: count down skip decrements register byte, skips when it reaches zero.
// RQ15: bit set and bit clear write one bit 0..7, others unchanged.
// RQ16: bit test runs next only when the selected bit is one.
// RQ17: soft irq flag clear resets pending flag, nothing else.
// RQ18: exchange swaps accumulator with direct or pointer addressed byte.
// RQ19: auto increment or decrement exchange steps the pointer by one afterwards.
// RQ20: accumulator load copies direct, pointer or immediate operand.
// RQ21: immediate loads write first pointer, direct byte or register byte.
// RQ22: a skipped instruction is fetched but acts as an idle op.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "mxd_cfg.svh"
module mxd_core (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    output logic      [14:0]  pmemAddr,
    output logic              pmemRd,
    input  wire logic [7:0]   pmemData
);
    import mxd_pkg::*;

    mxd_state_t r_q;
    mxd_state_t r_d;
    logic [7:0] mem [0:255];

    logic       memWe;
    logic [7:0] memWa;
    logic [7:0] memWd;
    logic       ptrWe;
    logic [7:0] ptrWa;
    logic [7:0] ptrWd;
    logic       apbMemWe;
    logic [7:0] ptrB; // see RQ3
    logic [7:0] ptrX;
    logic [7:0] ea;
    logic [7:0] opnd;
    logic [7:0] regAddr;
    logic [7:0] decVal;
    logic [7:0] bitSrc;
    logic       busy;
    logic       apbAsk;
    logic       apbDone;
    logic       execNow;
    logic [8:0] adcExp;
    logic [8:0] subExp;
    logic       gtHit;

    mxd_alu_if aluBus ();

    mxd_alu u_alu (
        .bus (aluBus.alu)
    );

    function automatic logic [1:0] instrBytes(input mxd_mode_t m);
        case (m)
            MD_DIR:  instrBytes = 2'd3;
            MD_IMM:  instrBytes = 2'd2;
            default: instrBytes = 2'd1;
        endcase
    endfunction

    function automatic logic [14:0] pcStep(input logic [6:0] hi, input logic [7:0] lo,
                                           input logic [1:0] n);
        pcStep = {hi, lo} + {13'h0000, n}; // see RQ4
    endfunction

    function automatic logic [7:0] bitMask(input logic [2:0] n);
        bitMask = 8'h01 << n;
    endfunction

    // pointers live in register memory, so software reaches them as bytes
    assign ptrB    = mem[`MXD_ADDR_B]; // see RQ6
    assign ptrX    = mem[`MXD_ADDR_X];
    assign regAddr = {`MXD_REG_PAGE, r_q.dir[3:0]};
    assign decVal  = mem[regAddr] - 8'h01;
    assign busy    = (r_q.st != ST_IDLE);
    assign apbAsk  = psel && penable && !r_q.pready;
    assign apbDone = psel && penable && r_q.pready;
    assign execNow = (r_q.st == ST_EXEC) && !r_q.skip;
    assign adcExp  = {1'b0, r_q.acc} + {1'b0, opnd} + {8'h00, r_q.carry};
    assign subExp  = {1'b0, r_q.acc} + {1'b0, ~opnd} + {8'h00, r_q.carry};
    assign gtHit   = r_q.acc > opnd;

    always_comb begin
        case (r_q.mode)
            MD_PB, MD_PB_INC, MD_PB_DEC: ea = ptrB;
            MD_PX, MD_PX_INC, MD_PX_DEC: ea = ptrX;
            default:                     ea = r_q.dir;
        endcase
        opnd   = (r_q.mode == MD_IMM) ? r_q.imm : mem[ea];
        bitSrc = (r_q.mode == MD_IMM) ? r_q.acc : opnd;
    end

    always_comb begin
        aluBus.a = r_q.acc;
        aluBus.b = opnd;
        case (r_q.op)
            OP_ADC:  aluBus.op = ALU_ADC;
            OP_DIFFERENCE_WITH_BORROW: aluBus.op = ALU_DIFFERENCE_WITH_BORROW;
            OP_AND:  aluBus.op = ALU_AND;
            OP_OR:   aluBus.op = ALU_OR;
            OP_XOR:  aluBus.op = ALU_XOR;
            default: aluBus.op = ALU_ADD;
        endcase
        // plain add forms its sum without the carry input
        aluBus.cin = (r_q.op == OP_ADD) ? 1'b0 : r_q.carry; // see RQ7
    end

    always_comb begin
        r_d      = r_q;
        memWe    = 1'b0;
        memWa    = ea;
        memWd    = 8'h00;
        ptrWe    = 1'b0;
        ptrWa    = r_q.mode[1] ? `MXD_ADDR_X : `MXD_ADDR_B;
        ptrWd    = r_q.mode[0] ? ea - 8'h01 : ea + 8'h01;
        apbMemWe = 1'b0;
        r_d.pready  = apbAsk;
        r_d.pslverr = 1'b0;
        r_d.pmemRd  = 1'b0;

        // answer is prepared one cycle ahead so every bus output is a flop
        if (apbAsk) begin
            r_d.prdata  = 32'h0000_0000;
            r_d.pslverr = pwrite && busy;
            case (paddr)
                `MXD_OFS_CMD:   r_d.prdata = {24'h00_0000, 3'h0, r_q.op};
                `MXD_OFS_ACC:   r_d.prdata = {24'h00_0000, r_q.acc};
                `MXD_OFS_PC:    r_d.prdata = {17'h0_0000, r_q.pcHi, r_q.pcLo};
                `MXD_OFS_PSW:   r_d.prdata = {28'h000_0000, r_q.softPend, r_q.global_irq_enable,
                                              r_q.half, r_q.carry};
                `MXD_OFS_STAT:  r_d.prdata = {30'h0000_0000, r_q.skip, busy};
                `MXD_OFS_MADDR: r_d.prdata = {24'h00_0000, r_q.memAddr};
                `MXD_OFS_MDATA: r_d.prdata = {24'h00_0000, mem[r_q.memAddr]};
                `MXD_OFS_VEC:   r_d.prdata = {17'h0_0000, r_q.vecAddr};
                default:        r_d.pslverr = 1'b1;
            endcase
        end

        if (apbDone && pwrite && !r_q.pslverr) begin
            case (paddr)
                `MXD_OFS_CMD: begin
                    r_d.op   = mxd_op_t'(pwdata[`MXD_CMD_OP_LSB +: 5]);
                    r_d.mode = mxd_mode_t'(pwdata[`MXD_CMD_MODE_LSB +: 3]);
                    r_d.imm  = pwdata[`MXD_CMD_IMM_LSB +: 8];
                    r_d.dir  = pwdata[`MXD_CMD_DIR_LSB +: 8];
                    r_d.bitn = pwdata[`MXD_CMD_BIT_LSB +: 3];
                    r_d.st   = ST_EXEC;
                end
                `MXD_OFS_ACC: r_d.acc = pwdata[7:0];
                `MXD_OFS_PC: begin
                    r_d.pcHi = pwdata[14:8];
                    r_d.pcLo = pwdata[7:0];
                end
                `MXD_OFS_PSW: begin
                    r_d.carry    = pwdata[`MXD_PSW_C];
                    r_d.half     = pwdata[`MXD_PSW_HC];
                    r_d.global_irq_enable      = pwdata[`MXD_PSW_GIE];
                    r_d.softPend = pwdata[`MXD_PSW_PEND];
                end
                `MXD_OFS_MADDR: r_d.memAddr = pwdata[7:0];
                `MXD_OFS_MDATA: apbMemWe = 1'b1;
                `MXD_OFS_VEC:   r_d.vecAddr = pwdata[14:0];
                default: ;
            endcase
        end

        case (r_q.st)
            ST_IDLE: ;
            ST_EXEC: begin
                r_d.st = ST_IDLE;
                {r_d.pcHi, r_d.pcLo} = pcStep(r_q.pcHi, r_q.pcLo, instrBytes(r_q.mode));
                if (r_q.skip) begin
                    // skipped op is fetched but alters nothing else
                    r_d.skip = 1'b0; // see RQ22
                end else begin
                    case (r_q.op)
                        OP_IDLE: ; // see RQ1
                        OP_ADD, OP_AND, OP_OR, OP_XOR: r_d.acc = aluBus.res; // see RQ9
                        OP_ADC, OP_DIFFERENCE_WITH_BORROW: begin
                            r_d.acc   = aluBus.res; // see RQ7
                            r_d.carry = aluBus.cout; // see RQ5
                            r_d.half  = aluBus.hcout; // see RQ8
                        end
                        OP_MASK_SKIP: r_d.skip = (r_q.acc & r_q.imm) == 8'h00; // see RQ10
                        OP_EQ_MD:     r_d.skip = mem[r_q.dir] != r_q.imm; // see RQ11
                        OP_EQ:        r_d.skip = r_q.acc != opnd; // see RQ12
                        OP_NE:        r_d.skip = r_q.acc == opnd;
                        OP_GT:        r_d.skip = !gtHit;
                        OP_NIB:       r_d.skip = ptrB[3:0] == r_q.imm[3:0]; // see RQ13
                        OP_CNT_SKIP: begin
                            memWe    = 1'b1; // see RQ14
                            memWa    = regAddr;
                            memWd    = decVal;
                            r_d.skip = decVal == 8'h00;
                        end
                        OP_BSET, OP_BCLR: begin
                            memWe = (r_q.mode != MD_IMM); // see RQ15
                            memWd = (r_q.op == OP_BSET) ? opnd | bitMask(r_q.bitn)
                                                        : opnd & ~bitMask(r_q.bitn);
                        end
                        OP_BTEST:    r_d.skip = !bitSrc[r_q.bitn]; // see RQ16
                        OP_PEND_CLR: r_d.softPend = 1'b0; // see RQ17
                        OP_XCHG: begin
                            r_d.acc = mem[ea]; // see RQ18
                            memWe   = 1'b1;
                            memWd   = r_q.acc;
                            ptrWe   = r_q.mode[2]; // see RQ19
                        end
                        OP_LDA: begin
                            r_d.acc = opnd; // see RQ20
                            ptrWe   = r_q.mode[2];
                        end
                        OP_LDB: begin
                            memWe = 1'b1; // see RQ21
                            memWa = `MXD_ADDR_B;
                            memWd = r_q.imm;
                        end
                        OP_LDMEM: begin
                            memWe = 1'b1;
                            memWd = r_q.imm;
                            ptrWe = r_q.mode[2];
                        end
                        OP_LDREG: begin
                            memWe = 1'b1;
                            memWa = regAddr;
                            memWd = r_q.imm;
                        end
                        OP_VEC: begin
                            // counter comes from the vector, not from the step
                            r_d.pcHi     = r_q.pcHi;
                            r_d.pcLo     = r_q.pcLo;
                            r_d.pmemAddr = r_q.vecAddr; // see RQ2
                            r_d.pmemRd   = 1'b1;
                            r_d.st       = ST_VHI;
                        end
                        default: ;
                    endcase
                end
            end
            ST_VHI: begin
                r_d.pmemAddr = r_q.vecAddr + 15'h0001;
                r_d.pmemRd   = 1'b1;
                r_d.st       = ST_VLO;
            end
            ST_VLO: begin
                r_d.pcHi = pmemData[6:0]; // see RQ2
                r_d.st   = ST_VEND;
            end
            ST_VEND: begin
                r_d.pcLo = pmemData;
                r_d.st   = ST_IDLE;
            end
            default: r_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r_q         <= '0;
            r_q.st      <= ST_IDLE;
            r_q.vecAddr <= `MXD_RST_VEC;
        end else begin
            r_q <= r_d;
        end
    end

    // no reset on the array: software must load the bytes it relies on
    always_ff @(posedge clk) begin
        if (memWe) begin
            mem[memWa] <= memWd;
        end
        if (ptrWe) begin
            mem[ptrWa] <= ptrWd; // see RQ19
        end
        if (apbMemWe) begin
            mem[r_q.memAddr] <= pwdata[7:0];
        end
    end

    assign prdata   = r_q.prdata;
    assign pready   = r_q.pready;
    assign pslverr  = r_q.pslverr;
    assign pmemAddr = r_q.pmemAddr;
    assign pmemRd   = r_q.pmemRd;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_IDLE_STILL: assert property (execNow && r_q.op == OP_IDLE |=> // see RQ1
        $stable(r_q.acc) && $stable(r_q.carry) && $stable(r_q.half) && !r_q.skip)
        else $error("idle op changed state");
    AST_VEC_LOAD: assert property (execNow && r_q.op == OP_VEC |-> // see RQ2
        ##1 pmemRd ##1 pmemRd ##2 (r_q.st == ST_IDLE && r_q.pcLo == $past(pmemData)))
        else $error("vector dispatch did not load the counter");
    AST_ADC_SUM: assert property (execNow && r_q.op == OP_ADC |=> // see RQ7
        {r_q.carry, r_q.acc} == $past(adcExp))
        else $error("add with carry result wrong");
    AST_DIFFERENCE_WITH_BORROW_SUM: assert property (execNow && r_q.op == OP_DIFFERENCE_WITH_BORROW |=> // see RQ8
        {r_q.carry, r_q.acc} == $past(subExp))
        else $error("difference with borrow result wrong");
    AST_GT_SKIP: assert property (execNow && r_q.op == OP_GT |=> // see RQ12
        r_q.skip == !$past(gtHit))
        else $error("greater test skip wrong");
    AST_CNT_ZERO: assert property (execNow && r_q.op == OP_CNT_SKIP // see RQ14
        && decVal == 8'h00 |=> r_q.skip ##1 r_q.skip)
        else $error("count down did not skip at zero");
    AST_PEND_CLR: assert property (execNow && r_q.op == OP_PEND_CLR |=> // see RQ17
        !r_q.softPend && $stable(r_q.acc) && $stable(r_q.carry))
        else $error("pending clear touched other state");
    AST_SKIP_NOP: assert property (r_q.st == ST_EXEC && r_q.skip |=> // see RQ22
        $stable(r_q.acc) && !r_q.skip && r_q.st == ST_IDLE)
        else $error("skipped op had an effect");

    COV_VEC:  cover property (execNow && r_q.op == OP_VEC ##4 r_q.st == ST_IDLE);
    COV_SKIP: cover property (r_q.st == ST_EXEC && r_q.skip);
    COV_CNT:  cover property (execNow && r_q.op == OP_CNT_SKIP && decVal == 8'h00);
endmodule

/* File: bench/mxd_pmem_model.sv */
`timescale 1ns/10ps
module mxd_pmem_model (
    input  wire logic        clk,
    input  wire logic [14:0] pmemAddr,
    input  wire logic        pmemRd,
    output logic      [7:0]  pmemData
);
    initial pmemData = 8'h5A;

    always @(posedge clk) begin
        if (pmemRd) begin
            pmemData <= pmemAddr[7:0] + 8'h63;
        end else begin
            pmemData <= ~pmemData;
        end
    end
endmodule

/* File: bench/mcu_execute_datapath_tb.sv */
`timescale 1ns/10ps
`include "mxd_cfg.svh"
module mcu_execute_datapath_tb;
    import mxd_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [14:0] pmemAddr;
    logic        pmemRd;
    logic [7:0]  pmemData;
    logic [31:0] rdV;
    logic        errV;
    int          err_total;
    int          n_compared;

    mxd_core u_mxd_core (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pmemAddr(pmemAddr), .pmemRd(pmemRd), .pmemData(pmemData));
    mxd_pmem_model u_mxd_pmem_model (.clk(clk), .pmemAddr(pmemAddr), .pmemRd(pmemRd),
        .pmemData(pmemData));

    always #12.5 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk iff pready === 1'b1);
        rdV  = prdata;
        errV = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic memw(input logic [7:0] a, input logic [7:0] v);
        wr(`MXD_OFS_MADDR, {24'h0, a});
        wr(`MXD_OFS_MDATA, {24'h0, v});
    endtask

    task automatic rm(input logic [7:0] a);
        wr(`MXD_OFS_MADDR, {24'h0, a});
        rd(`MXD_OFS_MDATA);
    endtask

    task automatic cmd(input mxd_op_t op, input mxd_mode_t md, input logic [7:0] imm,
                       input logic [7:0] dir, input logic [2:0] bn);
        wr(`MXD_OFS_CMD, {5'h00, bn, dir, imm, md, op});
        do begin
            rd(`MXD_OFS_STAT);
        end while (rdV[`MXD_STAT_BUSY] !== 1'b0);
    endtask

    task automatic t_regs;
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h0);
        rd(`MXD_OFS_PSW);
        chk(rdV, 32'h0);
        rd(`MXD_OFS_VEC);
        chk(rdV, 32'h00FE);
        wr(`MXD_OFS_ACC, 32'hFFFFFFFF);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'hFF);
        wr(`MXD_OFS_PC, 32'hFFFFFFFF);
        rd(`MXD_OFS_PC);
        chk(rdV, 32'h7FFF);
        wr(`MXD_OFS_PSW, 32'hFF);
        rd(`MXD_OFS_PSW);
        chk(rdV, 32'h0F);
        wr(8'h20, 32'h1);
        chk({31'h0, errV}, 32'h1);
        rd(8'h20);
        chk(rdV, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_arith;
        wr(`MXD_OFS_PSW, 32'h1);
        wr(`MXD_OFS_ACC, 32'h3A);
        cmd(OP_ADC, MD_IMM, 8'h47, 8'h00, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h82);
        rd(`MXD_OFS_PSW);
        chk(rdV, 32'h2);
        wr(`MXD_OFS_PSW, 32'h1);
        cmd(OP_ADD, MD_IMM, 8'hF0, 8'h00, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h72);
        wr(`MXD_OFS_ACC, 32'h50);
        cmd(OP_DIFFERENCE_WITH_BORROW, MD_IMM, 8'h20, 8'h00, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h30);
        rd(`MXD_OFS_PSW);
        chk(rdV, 32'h3);
        $display("test arith done");
    endtask

    task automatic t_logic;
        memw(8'h20, 8'hCC);
        memw(`MXD_ADDR_B, 8'h20);
        wr(`MXD_OFS_ACC, 32'hAA);
        cmd(OP_AND, MD_DIR, 8'h00, 8'h20, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h88);
        cmd(OP_OR, MD_IMM, 8'h01, 8'h00, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h89);
        cmd(OP_XOR, MD_PB, 8'h00, 8'h00, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h45);
        $display("test logic done");
    endtask

    task automatic t_skip1(input mxd_op_t op, input mxd_mode_t md, input logic [7:0] imm,
                           input logic [7:0] dir, input logic [2:0] bn, input logic sk);
        wr(`MXD_OFS_ACC, 32'h10);
        wr(`MXD_OFS_PC, 32'h0);
        cmd(op, md, imm, dir, bn);
        chk({31'h0, rdV[`MXD_STAT_SKIP]}, {31'h0, sk});
        cmd(OP_ADD, MD_IMM, 8'h01, 8'h00, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, sk ? 32'h10 : 32'h11);
        rd(`MXD_OFS_PC);
        chk(rdV, (md == MD_DIR) ? 32'h5 : (md == MD_IMM) ? 32'h4 : 32'h3);
    endtask

    task automatic t_skip;
        t_skip1(OP_MASK_SKIP, MD_IMM, 8'h01, 8'h00, 3'h0, 1'b1);
        t_skip1(OP_MASK_SKIP, MD_IMM, 8'h10, 8'h00, 3'h0, 1'b0);
        t_skip1(OP_EQ_MD, MD_DIR, 8'hCC, 8'h20, 3'h0, 1'b0);
        t_skip1(OP_EQ_MD, MD_DIR, 8'hCD, 8'h20, 3'h0, 1'b1);
        t_skip1(OP_EQ, MD_IMM, 8'h10, 8'h00, 3'h0, 1'b0);
        t_skip1(OP_EQ, MD_IMM, 8'h11, 8'h00, 3'h0, 1'b1);
        t_skip1(OP_NE, MD_IMM, 8'h10, 8'h00, 3'h0, 1'b1);
        t_skip1(OP_NE, MD_IMM, 8'h11, 8'h00, 3'h0, 1'b0);
        t_skip1(OP_GT, MD_IMM, 8'h0F, 8'h00, 3'h0, 1'b0);
        t_skip1(OP_GT, MD_IMM, 8'h10, 8'h00, 3'h0, 1'b1);
        t_skip1(OP_NIB, MD_IMM, 8'h00, 8'h00, 3'h0, 1'b1);
        t_skip1(OP_NIB, MD_IMM, 8'h05, 8'h00, 3'h0, 1'b0);
        t_skip1(OP_BTEST, MD_IMM, 8'h00, 8'h00, 3'h4, 1'b0);
        t_skip1(OP_BTEST, MD_IMM, 8'h00, 8'h00, 3'h3, 1'b1);
        t_skip1(OP_BTEST, MD_DIR, 8'h00, 8'h20, 3'h2, 1'b0);
        $display("test skip done");
    endtask

    task automatic t_count;
        memw(8'hF5, 8'h02);
        cmd(OP_CNT_SKIP, MD_DIR, 8'h00, 8'h05, 3'h0);
        chk({31'h0, rdV[`MXD_STAT_SKIP]}, 32'h0);
        cmd(OP_CNT_SKIP, MD_DIR, 8'h00, 8'h05, 3'h0);
        chk({31'h0, rdV[`MXD_STAT_SKIP]}, 32'h1);
        rm(8'hF5);
        chk(rdV, 32'h0);
        cmd(OP_IDLE, MD_DIR, 8'h00, 8'h00, 3'h0);
        $display("test count done");
    endtask

    task automatic t_bits;
        memw(8'h30, 8'h00);
        for (int b = 0; b < 8; b++) begin
            cmd(OP_BSET, MD_DIR, 8'h00, 8'h30, 3'(b));
            rm(8'h30);
            chk(rdV, 32'((1 << (b + 1)) - 1));
        end
        cmd(OP_BCLR, MD_DIR, 8'h00, 8'h30, 3'h0);
        cmd(OP_BCLR, MD_DIR, 8'h00, 8'h30, 3'h7);
        rm(8'h30);
        chk(rdV, 32'h7E);
        $display("test bits done");
    endtask

    task automatic t_pend;
        wr(`MXD_OFS_PSW, 32'hF);
        wr(`MXD_OFS_ACC, 32'h5A);
        cmd(OP_PEND_CLR, MD_PB, 8'h00, 8'h00, 3'h0);
        rd(`MXD_OFS_PSW);
        chk(rdV, 32'h7);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h5A);
        $display("test pend done");
    endtask

    task automatic t_xchg;
        wr(`MXD_OFS_ACC, 32'h11);
        memw(8'h40, 8'h22);
        cmd(OP_XCHG, MD_DIR, 8'h00, 8'h40, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h22);
        memw(`MXD_ADDR_X, 8'h40);
        cmd(OP_XCHG, MD_PX_INC, 8'h00, 8'h00, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h11);
        rm(`MXD_ADDR_X);
        chk(rdV, 32'h41);
        memw(8'h41, 8'h33);
        memw(`MXD_ADDR_B, 8'h41);
        cmd(OP_XCHG, MD_PB_DEC, 8'h00, 8'h00, 3'h0);
        rm(8'h41);
        chk(rdV, 32'h11);
        rm(`MXD_ADDR_B);
        chk(rdV, 32'h40);
        $display("test xchg done");
    endtask

    task automatic t_load;
        cmd(OP_LDA, MD_PX, 8'h00, 8'h00, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h11);
        cmd(OP_LDA, MD_IMM, 8'h77, 8'h00, 3'h0);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h77);
        cmd(OP_LDB, MD_IMM, 8'h33, 8'h00, 3'h0);
        rm(`MXD_ADDR_B);
        chk(rdV, 32'h33);
        cmd(OP_LDMEM, MD_DIR, 8'h99, 8'h50, 3'h0);
        rm(8'h50);
        chk(rdV, 32'h99);
        cmd(OP_LDREG, MD_DIR, 8'hAB, 8'h0D, 3'h0);
        rm(`MXD_ADDR_SP);
        chk(rdV, 32'hAB);
        $display("test load done");
    endtask

    task automatic t_vec;
        wr(`MXD_OFS_ACC, 32'h66);
        wr(`MXD_OFS_VEC, 32'h0120);
        wr(`MXD_OFS_CMD, {24'h0, MD_DIR, OP_VEC});
        wr(`MXD_OFS_ACC, 32'h0);
        chk({31'h0, errV}, 32'h1);
        cmd(OP_IDLE, MD_PB, 8'h00, 8'h00, 3'h0);
        rd(`MXD_OFS_PC);
        chk(rdV, 32'h0385);
        rd(`MXD_OFS_ACC);
        chk(rdV, 32'h66);
        $display("test vec done");
    endtask

    task automatic t_idle;
        wr(`MXD_OFS_PC, 32'h10);
        wr(`MXD_OFS_PSW, 32'h5);
        memw(8'h60, 8'hA5);
        cmd(OP_IDLE, MD_PB, 8'h00, 8'h00, 3'h0);
        rd(`MXD_OFS_PC);
        chk(rdV, 32'h11);
        rd(`MXD_OFS_PSW);
        chk(rdV, 32'h5);
        rm(8'h60);
        chk(rdV, 32'hA5);
        $display("test idle done");
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #500000;
        err_total++;
        complete_run();
    end

    initial begin
        clk        = 1'b0;
        rst_b      = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        err_total  = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_arith();
        t_logic();
        t_skip();
        t_count();
        t_bits();
        t_pend();
        t_xchg();
        t_load();
        t_vec();
        t_idle();
        complete_run();
    end
endmodule
